/* File: design/bhc_pkg.sv */
/*
  Constants, flag layout and state encoding for the buck fault and hiccup
  controller. Assumes a 40 MHz system clock.
*/
`default_nettype none
package bhc_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Internal oscillator phase frequency (RT pin setting stands in here)
  localparam int PHASE_FREQ_KHZ = 400;
  localparam int PERIOD_CYC = CLK_HZ / (PHASE_FREQ_KHZ * 1000);
  localparam logic [7:0] PERIOD_LAST = 8'(PERIOD_CYC - 1);
  localparam logic [7:0] PERIOD_HALF = 8'(PERIOD_CYC / 2);
  // Longest quiet time on the enable/sync pin while still counted as a clock
  localparam int SYNC_LOSS_NS = 4000;
  localparam int SYNC_LOSS_CYC = (SYNC_LOSS_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] SYNC_LOSS_MAX = 8'(SYNC_LOSS_CYC);
  // External clock divided by eight, second phase half way
  localparam logic [2:0] SYNC_DIV_PH0 = 3'h0;
  localparam logic [2:0] SYNC_DIV_PH1 = 3'h4;
  localparam logic [1:0] SYNC_EDGES_MIN = 2'h2;
  // ==========================================================================
  // Fault counting
  localparam logic [4:0] OC_WINDOW_LAST = 5'h1f;  // 32 cycles per window
  localparam logic [2:0] OC_LIMIT = 3'h7;
  localparam logic [2:0] HICCUP_CYCLES = 3'h7;
  // ==========================================================================
  // Synchronised flag vector layout
  localparam int FLG_EN = 0;
  localparam int FLG_POR = 1;
  localparam int FLG_BP = 2;
  localparam int FLG_UV_ON = 3;
  localparam int FLG_UV_OFF = 4;
  localparam int FLG_FB_UV = 5;
  localparam int FLG_FB_WIN = 6;
  localparam int FLG_OV = 7;
  localparam int FLG_SS_1V = 8;
  localparam int FLG_SS_LOW = 9;
  localparam int FLG_OC0 = 10;
  localparam int FLG_PWM0 = 12;
  localparam int NFLAGS = 14;
  localparam int NPHASE = 2;
  // ==========================================================================
  // Fault control states
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_SOFT = 3'h1,
    ST_RUN = 3'h2,
    ST_HIC_FLUSH = 3'h3,
    ST_HIC_CHG = 3'h4,
    ST_HIC_DIS = 3'h5
  } bhc_state_t;
endpackage : bhc_pkg
`default_nettype wire

/* File: design/bhc_osc_if.sv */
/*
  Link between the fault controller and its cycle generator.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface bhc_osc_if;
  logic en_level;
  logic enabled;
  logic [1:0] cycle_start;
  modport osc (input en_level, output enabled, output cycle_start);
  modport ctl (output en_level, input enabled, input cycle_start);
endinterface : bhc_osc_if
`default_nettype wire

/* File: design/bhc_osc.sv */
/*
  Cycle generator: internal oscillator or external clock divided by eight,
  two phases 180 degrees apart. Assumes en_level is already synchronised.
*/
`default_nettype none
module bhc_osc
  import bhc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  bhc_osc_if.osc osc
);
  // ==========================================================================
  // Sync detection
  logic en_q_r;
  logic fall;
  logic [7:0] quiet_r;
  logic [1:0] edges_r;
  logic sync_on;
  logic [2:0] div_r;
  logic [7:0] per_r;
  logic [1:0] start_r;
  logic enabled_r;

  assign fall = en_q_r & ~osc.en_level;
  // Two edges needed, so a plain enable going low is not taken as a clock
  assign sync_on = (edges_r == SYNC_EDGES_MIN) && (quiet_r < SYNC_LOSS_MAX);

  // Edge history and quiet-time watchdog
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      en_q_r <= 1'b0;
      quiet_r <= SYNC_LOSS_MAX;
      edges_r <= 2'h0;
    end else begin
      en_q_r <= osc.en_level;
      if (fall) begin
        quiet_r <= 8'h00;
        if (edges_r != SYNC_EDGES_MIN) edges_r <= edges_r + 2'h1;
      end else if (quiet_r < SYNC_LOSS_MAX) begin
        quiet_r <= quiet_r + 8'h01;
      end else begin
        edges_r <= 2'h0;
      end
    end
  end

  // ==========================================================================
  // Cycle starts: falling sync edges counted by eight, else internal period
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_r <= 3'h0;
      per_r <= 8'h00;
      start_r <= 2'h0;
      enabled_r <= 1'b0;
    end else begin
      enabled_r <= osc.en_level | sync_on;
      per_r <= (per_r == PERIOD_LAST) ? 8'h00 : per_r + 8'h01;
      if (sync_on) begin
        start_r <= 2'h0;
        if (fall) begin
          div_r <= div_r + 3'h1;
          start_r <= {div_r == SYNC_DIV_PH1, div_r == SYNC_DIV_PH0};
        end
      end else begin
        div_r <= 3'h0;
        start_r <= {per_r == PERIOD_HALF, per_r == 8'h00};
      end
    end
  end

  assign osc.cycle_start = start_r;
  assign osc.enabled = enabled_r;
endmodule : bhc_osc
`default_nettype wire

/* File: design/bhc_fault_ctl.sv */
/*
  Fault, soft-start and hiccup sequencing of a two-phase buck controller,
  with gate-drive commands and the open-drain power-good indication.
  Assumes all flag inputs are comparator outputs from the analog front end,
  asynchronous to clk_i, and that the drivers add their own dead time.
  No dead time here: the low side turns on the cycle the high side drops.
*/
`default_nettype none
module bhc_fault_ctl
  import bhc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_sync_i,
  input wire logic por_ok_i,
  input wire logic filtered_supply_ok_i,
  input wire logic input_undervolt_lockout_on_i,
  input wire logic input_undervolt_lockout_off_i,
  input wire logic feedback_input_uv_i,
  input wire logic feedback_input_win_i,
  input wire logic overvoltage_set_input_ov_i,
  input wire logic ss_above_1v_i,
  input wire logic ss_discharged_i,
  input wire logic [1:0] current_limit_input_oc_i,
  input wire logic [1:0] pwm_end_i,
  output logic ss_charge_o,
  output logic ss_discharge_o,
  output logic [1:0] high_side_drive_o,
  output logic [1:0] low_side_drive_o,
  output logic power_good_out_o,
  output logic power_good_out_oe_n_o,
  output logic hiccup_active_o
);
  // ==========================================================================
  // Input synchronisers
  logic [NFLAGS-1:0] raw;
  logic [NFLAGS-1:0] meta_r;
  logic [NFLAGS-1:0] flag_r;

  // Order matches the flag positions of the package
  assign raw = {pwm_end_i, current_limit_input_oc_i, ss_discharged_i,
                ss_above_1v_i, overvoltage_set_input_ov_i, feedback_input_win_i,
                feedback_input_uv_i, input_undervolt_lockout_off_i,
                input_undervolt_lockout_on_i, filtered_supply_ok_i, por_ok_i,
                enable_sync_i};

  // Two flops per flag; only the second stage is read anywhere
  genvar gi;
  generate
    for (gi = 0; gi < NFLAGS; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          meta_r[gi] <= 1'b0;
          flag_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= raw[gi];
          flag_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  // Named views of the synchronised flags
  logic f_por;
  logic f_bp;
  logic f_uv_on;
  logic f_uv_off;
  logic f_fb_uv;
  logic f_fb_win;
  logic f_ov;
  logic f_ss_1v;
  logic f_ss_low;
  logic [1:0] f_oc;
  logic [1:0] f_pwm_end;

  assign f_por = flag_r[FLG_POR];
  assign f_bp = flag_r[FLG_BP];
  assign f_uv_on = flag_r[FLG_UV_ON];
  assign f_uv_off = flag_r[FLG_UV_OFF];
  assign f_fb_uv = flag_r[FLG_FB_UV];
  assign f_fb_win = flag_r[FLG_FB_WIN];
  assign f_ov = flag_r[FLG_OV];
  assign f_ss_1v = flag_r[FLG_SS_1V];
  assign f_ss_low = flag_r[FLG_SS_LOW];
  assign f_oc = flag_r[FLG_OC0 +: NPHASE];
  assign f_pwm_end = flag_r[FLG_PWM0 +: NPHASE];

  // ==========================================================================
  // Cycle generator
  bhc_osc_if osc_if ();

  // Only the synchronised level reaches the sync edge detector
  assign osc_if.en_level = flag_r[FLG_EN];

  // Phase starts come as one-cycle pulses, phase 1 half a period later
  bhc_osc bhc_osc_inst (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .osc(osc_if.osc)
  );

  // Enable is the plain level or a running sync clock
  logic enabled;
  logic [1:0] cyc_start;

  assign enabled = osc_if.enabled;
  assign cyc_start = osc_if.cycle_start;

  // ==========================================================================
  // Programmable undervoltage lockout, hysteresis between the two trips
  logic input_undervolt_lockout_run_r;

  // Off trip wins over on trip, so a sagging input always shuts down
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      input_undervolt_lockout_run_r <= 1'b0;
    end else if (f_uv_off) begin
      input_undervolt_lockout_run_r <= 1'b0;
    end else if (f_uv_on) begin
      input_undervolt_lockout_run_r <= 1'b1;
    end
  end

  // Every condition that must hold before anything may switch
  logic supplies_ok;
  logic start_ok;

  assign supplies_ok = f_por & f_bp;
  assign start_ok = enabled & supplies_ok & input_undervolt_lockout_run_r;

  // ==========================================================================
  // Overcurrent event counting over 32-cycle windows
  logic oc_seen_r;
  logic [4:0] oc_win_r;
  logic [2:0] oc_cnt_r;
  logic oc_any;
  logic oc_event;
  logic [2:0] oc_base;

  bhc_state_t state_r;
  bhc_state_t state_nxt;

  // Either phase at its limit marks the whole cycle as an overcurrent cycle
  assign oc_any = |f_oc;
  assign oc_event = oc_seen_r | oc_any;
  // Window clear and an event in the same cycle: the event still counts
  assign oc_base = (oc_win_r == OC_WINDOW_LAST) ? 3'h0 : oc_cnt_r;

  // Seen flag per cycle, counted at each phase-0 cycle start
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oc_seen_r <= 1'b0;
      oc_win_r <= 5'h00;
      oc_cnt_r <= 3'h0;
    end else if (state_r != ST_RUN) begin
      // Counting restarts fresh so soft-start events cannot trip hiccup
      oc_seen_r <= 1'b0;
      oc_win_r <= 5'h00;
      oc_cnt_r <= 3'h0;
    end else if (cyc_start[0]) begin
      oc_seen_r <= 1'b0;
      oc_win_r <= oc_win_r + 5'h01;
      if (oc_base != OC_LIMIT) begin
        oc_cnt_r <= oc_base + {2'h0, oc_event};
      end else begin
        oc_cnt_r <= oc_base;
      end
    end else if (oc_any) begin
      oc_seen_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Fault sequencing state machine
  logic [2:0] hic_cnt_r;
  logic fault_trip;

  // Faults only count once soft-start has passed 1 V
  assign fault_trip = (oc_cnt_r == OC_LIMIT) | f_fb_uv;

  // Next state; lockout is applied last so it overrides every branch
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Idle, soft-start held empty until every start condition holds
      ST_OFF: begin
        if (start_ok && f_ss_low) state_nxt = ST_SOFT;
      end
      // Switching with faults masked until soft-start passes 1 V
      ST_SOFT: begin
        if (f_ss_1v) state_nxt = ST_RUN;
      end
      // Regulating; a sagging soft-start node falls back to the masked state
      ST_RUN: begin
        if (!f_ss_1v) state_nxt = ST_SOFT;
        else if (fault_trip) state_nxt = ST_HIC_FLUSH;
      end
      // Empty the capacitor first; this discharge is not a hiccup cycle
      ST_HIC_FLUSH: begin
        if (f_ss_low) state_nxt = ST_HIC_CHG;
      end
      // Hiccup charge, no switching
      ST_HIC_CHG: begin
        if (f_ss_1v) state_nxt = ST_HIC_DIS;
      end
      // Hiccup discharge; the seventh hands over to a normal soft-start
      ST_HIC_DIS: begin
        if (f_ss_low) begin
          if (hic_cnt_r == HICCUP_CYCLES - 3'h1) state_nxt = ST_SOFT;
          else state_nxt = ST_HIC_CHG;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    // Lockout overrides everything, from any state
    if (!start_ok) state_nxt = ST_OFF;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  // Completed hiccup cycles, counted at each discharge end that returns to charge
  // The flush ahead of the first charge never reaches this count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hic_cnt_r <= 3'h0;
    end else if (state_r == ST_HIC_DIS && state_nxt == ST_HIC_CHG) begin
      hic_cnt_r <= hic_cnt_r + 3'h1;
    end else if (state_r != ST_HIC_DIS && state_r != ST_HIC_CHG) begin
      hic_cnt_r <= 3'h0;
    end
  end

  // ==========================================================================
  // Soft-start pin control
  logic ss_chg_r;
  logic ss_dis_r;
  logic hic_r;

  // Decided from the next state so the pin follows the state with no lag
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ss_chg_r <= 1'b0;
      ss_dis_r <= 1'b1;
      hic_r <= 1'b0;
    end else begin
      ss_chg_r <= (state_nxt == ST_SOFT) || (state_nxt == ST_RUN) ||
                  (state_nxt == ST_HIC_CHG);
      ss_dis_r <= (state_nxt == ST_OFF) || (state_nxt == ST_HIC_FLUSH) ||
                  (state_nxt == ST_HIC_DIS);
      hic_r <= (state_nxt == ST_HIC_FLUSH) || (state_nxt == ST_HIC_CHG) ||
               (state_nxt == ST_HIC_DIS);
    end
  end

  // ==========================================================================
  // Gate drives, one block per phase
  logic sw_allow;
  logic ov_active;
  logic [1:0] on_r;
  logic [1:0] hs_r;
  logic [1:0] ls_r;

  // Overvoltage is masked during soft-start, like every fault but current
  assign ov_active = (state_nxt == ST_RUN) & f_ov;
  // Hiccup, off and lockout states never switch. Taken from the next state
  // so the drives drop on the same edge as the hiccup flag rises, with no
  // stray on-cycle left over from the run state
  assign sw_allow = ((state_nxt == ST_SOFT) | (state_nxt == ST_RUN)) & start_ok;

  generate
    for (gi = 0; gi < NPHASE; gi++) begin : g_phase
      logic on_nxt;
      // One on-time per start pulse, cut by current limit or PWM end
      always_comb begin
        on_nxt = on_r[gi];
        if (!sw_allow || ov_active) on_nxt = 1'b0;
        else if (f_oc[gi] || f_pwm_end[gi]) on_nxt = 1'b0;
        else if (cyc_start[gi]) on_nxt = 1'b1;
      end
      // Drive registers of this phase
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          on_r[gi] <= 1'b0;
          hs_r[gi] <= 1'b0;
          ls_r[gi] <= 1'b0;
        end else begin
          on_r[gi] <= on_nxt;
          hs_r[gi] <= on_nxt;
          // Rectifier conducts while switching and high side is off
          ls_r[gi] <= ov_active | (sw_allow & ~on_nxt);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Power-good: released only in regulation with every monitor in limits
  logic pg_ok_r;

  // Registered, so a one-cycle overlap of flags cannot glitch the pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pg_ok_r <= 1'b0;
    end else begin
      pg_ok_r <= (state_r == ST_RUN) & f_ss_1v & enabled &
                 supplies_ok & input_undervolt_lockout_run_r & f_fb_win & ~f_fb_uv & ~f_ov;
    end
  end

  // Open drain: pin value is always low, enable low means pulling down
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe_n_o = pg_ok_r;

  // Registered commands to the drivers and the soft-start pin
  assign ss_charge_o = ss_chg_r;
  assign ss_discharge_o = ss_dis_r;
  assign high_side_drive_o = hs_r;
  assign low_side_drive_o = ls_r;
  assign hiccup_active_o = hic_r;
endmodule : bhc_fault_ctl
`default_nettype wire

/* File: tb/bhc_fault_ctl_properties.sv */
/*
  Port checks for the buck fault and hiccup controller.
  Assumes a bind to bhc_fault_ctl, one clock and a synchronous reset.
*/
`default_nettype none
module bhc_fault_ctl_properties (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_ok_i,
  input wire logic filtered_supply_ok_i,
  input wire logic input_undervolt_lockout_off_i,
  input wire logic feedback_input_uv_i,
  input wire logic feedback_input_win_i,
  input wire logic overvoltage_set_input_ov_i,
  input wire logic ss_above_1v_i,
  input wire logic [1:0] current_limit_input_oc_i,
  input wire logic [1:0] high_side_drive_o,
  input wire logic [1:0] low_side_drive_o,
  input wire logic power_good_out_oe_n_o,
  input wire logic hiccup_active_o
);
  // ==========================================================================
  // Flags pass two sync flops and a register, so waits are 4 to 6 cycles
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic drv_off;
  assign drv_off = (high_side_drive_o == 2'h0) && (low_side_drive_o == 2'h0);
  sequence s_uv_in_run;
    power_good_out_oe_n_o ##1 feedback_input_uv_i [*2];
  endsequence
  sequence s_ov_in_run;
    (overvoltage_set_input_ov_i && ss_above_1v_i) [*6];
  endsequence
  a_por_lock_off: assert property (!por_ok_i [*6] |-> drv_off)
    else $error("gate drive active without power-on-clear");
  a_bp_lock_off: assert property (!filtered_supply_ok_i [*6] |-> drv_off)
    else $error("gate drive active with low filtered supply");
  a_input_undervolt_lockout_shut_off: assert property (input_undervolt_lockout_off_i [*6] |-> drv_off)
    else $error("gate drive active below undervoltage level");
  a_hiccup_drv_off: assert property (hiccup_active_o |-> drv_off)
    else $error("gate drive active in hiccup");
  a_oc_ends_on: assert property (current_limit_input_oc_i[0] [*4] |-> !high_side_drive_o[0])
    else $error("high side still on over current limit");
  a_ov_high_off: assert property (s_ov_in_run |-> high_side_drive_o == 2'h0)
    else $error("high side on during overvoltage");
  a_pg_soft_low: assert property (!ss_above_1v_i [*5] |-> !power_good_out_oe_n_o)
    else $error("power good released below 1 V soft-start");
  a_pg_win_low: assert property (!feedback_input_win_i [*5] |-> !power_good_out_oe_n_o)
    else $error("power good released out of window");
  a_fbuv_hiccup: assert property (s_uv_in_run |-> ##[1:6] hiccup_active_o)
    else $error("no hiccup after feedback undervoltage");
endmodule : bhc_fault_ctl_properties
`default_nettype wire

/* File: tb/bhc_afe_model.sv */
/*
  Analog front end stand-in: soft-start node and PWM comparators.
  Assumes gate and soft-start commands from the controller.
*/
`default_nettype none
module bhc_afe_model #(
  parameter int SS_1V = 20,
  parameter int SS_TOP = 30,
  parameter int ON_CYC = 30
) (
  input wire logic clk_i,
  input wire logic ss_charge_i,
  input wire logic ss_discharge_i,
  input wire logic ss_clamp_i,
  input wire logic [1:0] hs_i,
  output logic ss_above_1v_o,
  output logic ss_discharged_o,
  output logic [1:0] pwm_end_o
);
  int lvl = 0;
  int on0 = 0;
  int on1 = 0;
  // ==========================================================================
  // Clamp stands for an external limit holding the node under 1 V
  always @(posedge clk_i) begin
    if (ss_discharge_i) begin
      lvl <= (lvl > 4) ? lvl - 4 : 0;
    end else if (ss_charge_i && lvl < (ss_clamp_i ? SS_1V - 2 : SS_TOP)) begin
      lvl <= lvl + 1;
    end
    on0 <= hs_i[0] ? on0 + 1 : 0;
    on1 <= hs_i[1] ? on1 + 1 : 0;
  end
  assign ss_above_1v_o = (lvl >= SS_1V);
  assign ss_discharged_o = (lvl == 0);
  assign pwm_end_o = {on1 >= ON_CYC, on0 >= ON_CYC};
endmodule : bhc_afe_model
`default_nettype wire

/* File: tb/bhc_fault_ctl_tb.sv */
/*
  Self-checking bench for the buck fault and hiccup controller.
  Assumes the front end model answers soft-start and PWM comparators.
*/
`default_nettype none
module bhc_fault_ctl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic en = 1'b0, por = 1'b0, bp = 1'b0, uv_on = 1'b0, uv_off = 1'b0;
  logic fb_uv = 1'b0, fb_win = 1'b0, ov = 1'b0, clamp = 1'b0, sync_on = 1'b0;
  logic [1:0] oc = 2'h0;
  logic [1:0] hs, ls, pwm_end;
  logic chg, dis, pg, pg_oe_n, hic, ss_1v, ss_dis, hic_seen, hs1_q;
  int cyc = 0, fails = 0, n_compared = 0, rises = 0, sdiv = 0, since_fall = 0;

  bhc_fault_ctl bhc_fault_ctl_inst (.clk_i(clk_i), .reset_i(reset_i),
    .enable_sync_i(en), .por_ok_i(por), .filtered_supply_ok_i(bp),
    .input_undervolt_lockout_on_i(uv_on), .input_undervolt_lockout_off_i(uv_off),
    .feedback_input_uv_i(fb_uv), .feedback_input_win_i(fb_win),
    .overvoltage_set_input_ov_i(ov), .ss_above_1v_i(ss_1v), .ss_discharged_i(ss_dis),
    .current_limit_input_oc_i(oc), .pwm_end_i(pwm_end), .ss_charge_o(chg),
    .ss_discharge_o(dis), .high_side_drive_o(hs), .low_side_drive_o(ls),
    .power_good_out_o(pg), .power_good_out_oe_n_o(pg_oe_n), .hiccup_active_o(hic));
  bhc_afe_model bhc_afe_model_inst (.clk_i(clk_i), .ss_charge_i(chg),
    .ss_discharge_i(dis), .ss_clamp_i(clamp), .hs_i(hs), .ss_above_1v_o(ss_1v),
    .ss_discharged_o(ss_dis), .pwm_end_o(pwm_end));

  // ==========================================================================
  // Clock, timeout ceiling and output watchers
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    since_fall++;
    if (hic === 1'b1) hic_seen = 1'b1;
    if (hs[1] === 1'b1 && hs1_q !== 1'b1) rises++;
    hs1_q = hs[1];
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end
  // External clock, 16 system clocks a period
  always @(posedge clk_i) begin
    if (sync_on) begin
      sdiv = (sdiv + 1) % 8;
      if (sdiv == 0) begin
        #2 en = ~en;
        if (!en) since_fall = 0;
      end
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic pick(input int s);
    case (s)
      0: return hic;
      1: return pg_oe_n;
      default: return hs[0];
    endcase
  endfunction : pick
  // Bounded wait, then compare
  task automatic await(input int s, input logic v, input int max);
    for (int i = 0; i < max && pick(s) !== v; i++) tick(1);
    check(pick(s), v);
  endtask : await

  task automatic t_start();
    tick(2);
    por = 1'b1;
    bp = 1'b1;
    uv_on = 1'b1;
    fb_win = 1'b1;
    tick(30);
    check({hs, ls, chg, dis, pg}, 7'h02);
    en = 1'b1;
    await(1, 1'b1, 300);
    check(ss_1v, 1'b1);
    await(2, 1'b1, 200);
    $display("start done");
  endtask : t_start
  task automatic t_ov();
    ov = 1'b1;
    tick(8);
    check({hs, ls}, 4'h3);
    ov = 1'b0;
    await(2, 1'b1, 200);
    await(1, 1'b1, 50);
    $display("overvoltage done");
  endtask : t_ov
  // Two bursts of six cycles at most, never in one 32-cycle window
  task automatic t_window();
    hic_seen = 1'b0;
    rises = 0;
    oc[0] = 1'b1;
    tick(450);
    oc[0] = 1'b0;
    tick(4000);
    oc[0] = 1'b1;
    tick(450);
    oc[0] = 1'b0;
    tick(50);
    check(hic_seen, 1'b0);
    check(rises >= 47, 1'b1);
    $display("window done");
  endtask : t_window
  task automatic t_hiccup();
    int n;
    logic prev;
    n = 0;
    oc[0] = 1'b1;
    await(0, 1'b1, 4500);
    prev = chg;
    for (int i = 0; i < 2000 && hic === 1'b1; i++) begin
      if (chg === 1'b1 && prev !== 1'b1) n++;
      prev = chg;
      tick(1);
    end
    check(16'(n), 16'h7);
    await(0, 1'b1, 4500);
    oc[0] = 1'b0;
    await(0, 1'b0, 2000);
    await(1, 1'b1, 300);
    $display("hiccup done");
  endtask : t_hiccup
  task automatic t_uv();
    fb_uv = 1'b1;
    await(0, 1'b1, 8);
    tick(1);
    check({hs, ls}, 4'h0);
    fb_uv = 1'b0;
    await(1, 1'b1, 1000);
    $display("undervoltage done");
  endtask : t_uv
  // Soft-start held under 1 V: only cycle cutting may act
  task automatic t_mask();
    en = 1'b0;
    tick(6);
    check({hs, ls, pg_oe_n}, 5'h0);
    clamp = 1'b1;
    fb_uv = 1'b1;
    fb_win = 1'b0;
    ov = 1'b1;
    oc[1] = 1'b1;
    en = 1'b1;
    hic_seen = 1'b0;
    tick(600);
    check({hic_seen, pg_oe_n, ss_1v}, 3'h0);
    clamp = 1'b0;
    fb_uv = 1'b0;
    fb_win = 1'b1;
    ov = 1'b0;
    oc[1] = 1'b0;
    await(1, 1'b1, 500);
    $display("masking done");
  endtask : t_mask
  task automatic t_lock();
    for (int k = 0; k < 3; k++) begin
      uv_off = (k == 0);
      uv_on = (k != 0);
      por = (k != 1);
      bp = (k != 2);
      tick(6);
      check({hs, ls, pg_oe_n}, 5'h0);
      uv_off = 1'b0;
      uv_on = 1'b1;
      por = 1'b1;
      bp = 1'b1;
      await(1, 1'b1, 500);
    end
    uv_on = 1'b0;
    tick(6);
    check(pg_oe_n, 1'b1);
    uv_on = 1'b1;
    $display("lockout done");
  endtask : t_lock
  task automatic t_sync();
    int t0;
    int a0;
    sync_on = 1'b1;
    for (int j = 0; j < 2; j++) begin
      await(2, 1'b0, 300);
      await(2, 1'b1, 300);
    end
    t0 = cyc;
    a0 = since_fall;
    await(2, 1'b0, 300);
    await(2, 1'b1, 300);
    check(16'(cyc - t0), 16'd128);
    check(16'(since_fall), 16'(a0));
    sync_on = 1'b0;
    tick(1);
    en = 1'b1;
    await(1, 1'b1, 500);
    $display("sync done");
  endtask : t_sync

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge clk_i);
    #2 reset_i = 1'b0;
    t_start();
    t_ov();
    t_window();
    t_hiccup();
    t_uv();
    t_mask();
    t_lock();
    t_sync();
    final_report();
  end
endmodule : bhc_fault_ctl_tb

bind bhc_fault_ctl bhc_fault_ctl_properties bhc_fault_ctl_properties_inst (
  .clk_i(clk_i), .reset_i(reset_i), .por_ok_i(por_ok_i),
  .filtered_supply_ok_i(filtered_supply_ok_i),
  .input_undervolt_lockout_off_i(input_undervolt_lockout_off_i),
  .feedback_input_uv_i(feedback_input_uv_i), .feedback_input_win_i(feedback_input_win_i),
  .overvoltage_set_input_ov_i(overvoltage_set_input_ov_i), .ss_above_1v_i(ss_above_1v_i),
  .current_limit_input_oc_i(current_limit_input_oc_i),
  .high_side_drive_o(high_side_drive_o), .low_side_drive_o(low_side_drive_o),
  .power_good_out_oe_n_o(power_good_out_oe_n_o), .hiccup_active_o(hiccup_active_o));
`default_nettype wire
